// ---- verilog/corr_pkg.sv ----
`default_nettype none
package corr_pkg;
   // Datapath word and operand widths
   localparam int WORD_W = 48;
   localparam int COEF_W = 16;
   localparam int RAW_W = 14;
   localparam int OUT_W = 14;
   localparam int CFG_W = 16;
   localparam int DIV_STEPS = WORD_W;
   typedef logic signed [WORD_W-1:0] word_t;
   typedef logic signed [COEF_W-1:0] coef_t;
   typedef logic [RAW_W-1:0] raw_t;

   // Temperature resolution field and its codes
   localparam int RES_LSB = 10;
   localparam int RES_MSB = 11;
   localparam logic [1:0] RES_8 = 2'h0;
   localparam logic [1:0] RES_10 = 2'h1;
   localparam logic [1:0] RES_12 = 2'h2;
   localparam raw_t MASK_8 = 14'h00FF;
   localparam raw_t MASK_10 = 14'h03FF;
   localparam raw_t MASK_12 = 14'h0FFF;
   localparam raw_t MASK_14 = 14'h3FFF;

   // Fixed-point scaling: right-shift counts after each product, and the divider's fraction bits
   localparam logic [5:0] TC1_SHIFT = 6'h0F;
   localparam logic [5:0] TC2_SHIFT = 6'h0F;
   localparam int DEN_FRAC = 15;
   localparam logic [5:0] GAIN_SHIFT = 6'h0D;
   localparam logic [5:0] SQ_SHIFT = 6'h0E;
   localparam logic [5:0] COEF_SHIFT = 6'h0F;
   localparam logic [5:0] T_SQ_SHIFT = 6'h18;
   localparam logic [5:0] T_LIN_SHIFT = 6'h0E;
   localparam logic [5:0] NO_SHIFT = 6'h00;

   // Fixed values in datapath units
   localparam word_t DEN_ONE = 48'h0000_0000_8000;
   localparam word_t MID_SCALE = 48'h0000_0000_2000;
   localparam word_t CAP_MIN = 48'h0000_0000_0000;
   localparam word_t CAP_MAX = 48'h0000_0000_3FFF;
   localparam word_t T_MIN = 48'hFFFF_FFFF_8000;
   localparam word_t T_MAX = 48'h0000_0000_7FFF;

   typedef enum {ST_IDLE, ST_DRIFT, ST_DIV_GO, ST_DIV_WAIT, ST_POLY} state_t;

   function automatic word_t clamp(word_t x, word_t lo, word_t hi);
      if (x < lo) return lo;
      if (x > hi) return hi;
      return x;
   endfunction : clamp

   function automatic word_t ext_coef(coef_t c);
      return word_t'(c);
   endfunction : ext_coef

   function automatic word_t ext_raw(raw_t r);
      word_t w;
      w = '0;
      w[RAW_W-1:0] = r;
      return w;
   endfunction : ext_raw

   function automatic raw_t res_mask(logic [1:0] code);
      case (code)
         RES_8: return MASK_8;
         RES_10: return MASK_10;
         RES_12: return MASK_12;
         default: return MASK_14;
      endcase
   endfunction : res_mask
endpackage : corr_pkg
`default_nettype wire

// ---- verilog/corr_links.sv ----
`timescale 1ns/1ps
`default_nettype none
interface mul_if;
   import corr_pkg::*;
   word_t a;
   word_t b;
   word_t p;
   logic [5:0] sh;
   modport unit (input a, input b, input sh, output p);
   modport user (output a, output b, output sh, input p);
endinterface : mul_if

interface div_if;
   import corr_pkg::*;
   logic start;
   logic done;
   word_t num;
   word_t den;
   word_t quo;
   modport unit (input start, input num, input den, output done, output quo);
   modport user (output start, output num, output den, input done, input quo);
endinterface : div_if
`default_nettype wire

// ---- verilog/corr_mul.sv ----
`timescale 1ns/1ps
`default_nettype none
module corr_mul
   import corr_pkg::*;
(
   // Operands and scaled product
   mul_if.unit m
);
   localparam logic signed [2*WORD_W-1:0] WIDE_MAX =
      {{(WORD_W+1){1'b0}}, {(WORD_W-1){1'b1}}};
   localparam logic signed [2*WORD_W-1:0] WIDE_MIN = ~WIDE_MAX;
   logic signed [2*WORD_W-1:0] full;
   logic signed [2*WORD_W-1:0] scaled;

   // Full-width product, so only the final clamp can lose range
   always_comb begin
      full = (2*WORD_W)'(m.a) * (2*WORD_W)'(m.b);
      scaled = full >>> m.sh;
      if (scaled > WIDE_MAX) begin
         m.p = WIDE_MAX[WORD_W-1:0];
      end else if (scaled < WIDE_MIN) begin
         m.p = WIDE_MIN[WORD_W-1:0];
      end else begin
         m.p = scaled[WORD_W-1:0];
      end
   end
endmodule : corr_mul
`default_nettype wire

// ---- verilog/corr_div.sv ----
`timescale 1ns/1ps
`default_nettype none
module corr_div
   import corr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Division request and answer
   div_if.unit d
);
   logic [WORD_W-1:0] quo_q;
   logic [WORD_W-1:0] dsr_q;
   logic [WORD_W:0] rem_q;
   logic [WORD_W:0] rem_sh;
   logic [7:0] cnt_q;
   logic busy_q;
   logic neg_q;
   logic done_q;

   assign rem_sh = {rem_q[WORD_W-1:0], quo_q[WORD_W-1]};
   assign d.done = done_q;
   assign d.quo = neg_q ? -word_t'(quo_q) : word_t'(quo_q);

   // Restoring division on magnitudes: fixed step count keeps latency constant
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         quo_q <= '0;
         dsr_q <= '0;
         rem_q <= '0;
         cnt_q <= '0;
         busy_q <= 1'b0;
         neg_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (d.start) begin
            quo_q <= d.num[WORD_W-1] ? -d.num : d.num;
            dsr_q <= d.den[WORD_W-1] ? -d.den : d.den;
            neg_q <= d.num[WORD_W-1] ^ d.den[WORD_W-1];
            rem_q <= '0;
            cnt_q <= 8'(DIV_STEPS);
            busy_q <= 1'b1;
         end else if (busy_q) begin
            if (rem_sh >= {1'b0, dsr_q}) begin
               rem_q <= rem_sh - {1'b0, dsr_q};
               quo_q <= {quo_q[WORD_W-2:0], 1'b1};
            end else begin
               rem_q <= rem_sh;
               quo_q <= {quo_q[WORD_W-2:0], 1'b0};
            end
            cnt_q <= cnt_q - 8'h01;
            if (cnt_q == 8'h01) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end
         end
      end
   end
endmodule : corr_div
`default_nettype wire

// ---- verilog/sensor_correction_math.sv ----
// Contract
// RULE1 - Two-region piece-wise or single-region third-order correction, chosen by configuration.
// RULE2 - Compensated value is (raw + offset + dT*drift terms) / (1 + dT*gain drift).
// RULE3 - dT is present raw temperature minus stored reference raw temperature.
// RULE4 - Offset coefficient acts about the mid-scale input point.
// RULE5 - Region-one operand is min of compensated value and break point.
// RULE6 - Region-two operand is compensated value minus break, never below zero.
// RULE7 - A stored raw break point separates region one from region two.
// RULE8 - Two-region output sums square term plus linear term per region.
// RULE9 - With one region, region-two gain and square coefficient contribute nothing.
// RULE10 - Third-order mode uses region-two square slot as cubic coefficient.
// RULE11 - Temperature output is square coef*raw^2 + gain*raw + offset.
// RULE12 - Temperature coefficients and result are 16-bit signed values.
// RULE13 - Software keeps first-order drift coefficients inside their documented limits.
// RULE14 - Software keeps second-order drift coefficients inside their documented limits.
// RULE15 - Calibrate with every setting at its final application value.
// RULE16 - Alarm-only users must run coefficient verification.
// RULE17 - Temperature resolution field bits 11:10 selects 8, 10, 12 or 14 bits.
// RULE18 - Valid strobe starts a sample; results come with done after fixed latency.
// RULE19 - Wide intermediates; final results saturate rather than wrap.
`timescale 1ns/1ps
`default_nettype none
module sensor_correction_math
   import corr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Raw sample pair from the converter
   input wire logic sample_valid,
   input wire raw_t raw_cap,
   input wire raw_t raw_temp,
   output logic busy,
   // Configuration
   input wire logic [CFG_W-1:0] temp_config,
   input wire logic third_order,
   input wire logic single_region,
   // Capacitance coefficients
   input wire coef_t offset_coef,
   input wire coef_t offset_drift_coef,
   input wire coef_t offset_drift_square_coef,
   input wire coef_t slope_drift_coef,
   input wire coef_t slope_drift_square_coef,
   input wire raw_t temp_ref_raw,
   input wire raw_t break_raw,
   input wire coef_t region_one_gain,
   input wire coef_t region_one_square_coef,
   input wire coef_t region_two_gain,
   input wire coef_t region_two_square_coef,
   // Temperature coefficients
   input wire coef_t temp_gain,
   input wire coef_t temp_offset,
   input wire coef_t temperature_square_coef,
   // Corrected results
   output logic [OUT_W-1:0] cap_out,
   output logic [COEF_W-1:0] temp_out,
   output logic result_done
);
   state_t state_q;
   logic [2:0] step_q;

   // Coefficient snapshot taken with the sample, so a reload mid-calculation is harmless
   word_t offs_q;
   word_t tco_q;
   word_t tco2_q;
   word_t tcg_q;
   word_t tcg2_q;
   word_t brk_q;
   word_t gain1_q;
   word_t sot1_q;
   word_t gain2_q;
   word_t sot2_q;
   word_t gain_t_q;
   word_t offs_t_q;
   word_t temp_sq_q;
   logic third_q;
   logic single_q;

   // Working registers
   word_t rawc_q;
   word_t rawt_q;
   word_t dt_q;
   word_t m_q;
   word_t num_q;
   word_t den_q;
   word_t r1_q;
   word_t r2_q;
   word_t g_q;
   word_t sq_q;
   word_t acc_q;
   word_t tacc_q;
   word_t drift_compensated_value;
   word_t cubic_coef;

   logic [OUT_W-1:0] cap_q;
   logic [COEF_W-1:0] temp_q;
   logic done_q;
   logic accept;
   word_t cap_sat;
   word_t temp_sat;
   word_t cap_two_sat;

   mul_if mul_l();
   div_if div_l();

   corr_mul u_mul (
      .m (mul_l.unit)
   );

   corr_div u_div (
      .clk (clk),
      .sys_rst (sys_rst),
      .d (div_l.unit)
   );

   assign busy = (state_q != ST_IDLE);
   assign accept = sample_valid && (state_q == ST_IDLE); // RULE18
   assign cap_out = cap_q;
   assign temp_out = temp_q;
   assign result_done = done_q;
   assign cubic_coef = sot2_q; // RULE10

   // Numerator is scaled up so the quotient keeps the raw-value scale
   assign div_l.start = (state_q == ST_DIV_GO);
   assign div_l.num = num_q <<< DEN_FRAC; // RULE2
   assign div_l.den = den_q;
   assign drift_compensated_value = div_l.quo + MID_SCALE; // RULE4

   assign cap_sat = clamp(acc_q, CAP_MIN, CAP_MAX); // RULE19
   assign temp_sat = clamp(tacc_q, T_MIN, T_MAX); // RULE12
   assign cap_two_sat = clamp(acc_q + g_q + mul_l.p, CAP_MIN, CAP_MAX); // RULE19

   // Sequencer: one shared multiplier, one product per cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= ST_IDLE;
         step_q <= '0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               step_q <= '0;
               if (accept) begin
                  state_q <= ST_DRIFT;
               end
            end
            ST_DRIFT: begin
               if (step_q == 3'h6) begin
                  step_q <= '0;
                  state_q <= ST_DIV_GO;
               end else begin
                  step_q <= step_q + 3'h1;
               end
            end
            ST_DIV_GO: begin
               state_q <= ST_DIV_WAIT;
            end
            ST_DIV_WAIT: begin
               if (div_l.done) begin
                  step_q <= '0;
                  state_q <= ST_POLY;
               end
            end
            ST_POLY: begin
               if (step_q == 3'h5) begin
                  step_q <= '0;
                  state_q <= ST_IDLE; // RULE18
               end else begin
                  step_q <= step_q + 3'h1;
               end
            end
            default: begin
               step_q <= '0;
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Capture of sample, configuration and coefficients
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rawc_q <= '0;
         rawt_q <= '0;
         dt_q <= '0;
         offs_q <= '0;
         tco_q <= '0;
         tco2_q <= '0;
         tcg_q <= '0;
         tcg2_q <= '0;
         brk_q <= '0;
         gain1_q <= '0;
         sot1_q <= '0;
         gain2_q <= '0;
         sot2_q <= '0;
         gain_t_q <= '0;
         offs_t_q <= '0;
         temp_sq_q <= '0;
         third_q <= 1'b0;
         single_q <= 1'b0;
      end else if (accept) begin
         rawc_q <= ext_raw(raw_cap);
         rawt_q <= ext_raw(raw_temp & res_mask(temp_config[RES_MSB:RES_LSB])); // RULE17
         dt_q <= ext_raw(raw_temp & res_mask(temp_config[RES_MSB:RES_LSB]))
            - ext_raw(temp_ref_raw); // RULE3
         offs_q <= ext_coef(offset_coef);
         tco_q <= ext_coef(offset_drift_coef);
         tco2_q <= ext_coef(offset_drift_square_coef);
         tcg_q <= ext_coef(slope_drift_coef);
         tcg2_q <= ext_coef(slope_drift_square_coef);
         brk_q <= ext_raw(break_raw); // RULE7
         gain1_q <= ext_coef(region_one_gain);
         sot1_q <= ext_coef(region_one_square_coef);
         gain2_q <= ext_coef(region_two_gain);
         sot2_q <= ext_coef(region_two_square_coef);
         gain_t_q <= ext_coef(temp_gain); // RULE12
         offs_t_q <= ext_coef(temp_offset);
         temp_sq_q <= ext_coef(temperature_square_coef);
         third_q <= third_order; // RULE1
         single_q <= single_region;
      end
   end

   // Operand selection for the shared multiplier
   always_comb begin
      mul_l.a = '0;
      mul_l.b = '0;
      mul_l.sh = NO_SHIFT;
      case (state_q)
         ST_DRIFT: begin
            case (step_q)
               3'h0: begin
                  mul_l.a = dt_q;
                  mul_l.b = tco2_q;
                  mul_l.sh = TC2_SHIFT; // RULE14
               end
               3'h1: begin
                  mul_l.a = dt_q;
                  mul_l.b = tco_q + m_q;
                  mul_l.sh = TC1_SHIFT; // RULE13
               end
               3'h2: begin
                  mul_l.a = dt_q;
                  mul_l.b = tcg2_q;
                  mul_l.sh = TC2_SHIFT;
               end
               3'h3: begin
                  mul_l.a = dt_q;
                  mul_l.b = tcg_q + m_q;
                  mul_l.sh = TC1_SHIFT;
               end
               3'h4: begin
                  mul_l.a = rawt_q;
                  mul_l.b = rawt_q;
                  mul_l.sh = NO_SHIFT;
               end
               3'h5: begin
                  mul_l.a = m_q;
                  mul_l.b = temp_sq_q;
                  mul_l.sh = T_SQ_SHIFT;
               end
               default: begin
                  mul_l.a = rawt_q;
                  mul_l.b = gain_t_q;
                  mul_l.sh = T_LIN_SHIFT;
               end
            endcase
         end
         ST_POLY: begin
            case (step_q)
               3'h0: begin
                  mul_l.a = r1_q;
                  mul_l.b = gain1_q;
                  mul_l.sh = GAIN_SHIFT;
               end
               3'h1: begin
                  mul_l.a = g_q;
                  mul_l.b = g_q;
                  mul_l.sh = SQ_SHIFT;
               end
               3'h2: begin
                  mul_l.a = sq_q;
                  mul_l.b = sot1_q;
                  mul_l.sh = COEF_SHIFT;
               end
               3'h3: begin
                  mul_l.a = third_q ? sq_q : r2_q;
                  mul_l.b = third_q ? g_q : gain2_q;
                  mul_l.sh = third_q ? SQ_SHIFT : GAIN_SHIFT;
               end
               3'h4: begin
                  mul_l.a = third_q ? m_q : g_q;
                  mul_l.b = third_q ? cubic_coef : g_q; // RULE10
                  mul_l.sh = third_q ? COEF_SHIFT : SQ_SHIFT;
               end
               default: begin
                  mul_l.a = sq_q;
                  mul_l.b = sot2_q;
                  mul_l.sh = COEF_SHIFT;
               end
            endcase
         end
         default: begin
            mul_l.a = '0;
            mul_l.b = '0;
            mul_l.sh = NO_SHIFT;
         end
      endcase
   end

   // Drift terms and the temperature polynomial
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         m_q <= '0;
         num_q <= '0;
         den_q <= DEN_ONE;
         tacc_q <= '0;
      end else if (state_q == ST_DRIFT) begin
         case (step_q)
            3'h0: m_q <= mul_l.p;
            3'h1: num_q <= rawc_q - MID_SCALE + offs_q + mul_l.p; // RULE2 RULE4
            3'h2: m_q <= mul_l.p;
            3'h3: den_q <= DEN_ONE + mul_l.p; // RULE2
            3'h4: m_q <= mul_l.p;
            3'h5: tacc_q <= mul_l.p; // RULE11
            default: tacc_q <= tacc_q + mul_l.p + offs_t_q; // RULE11
         endcase
      end else if (state_q == ST_POLY && step_q == 3'h3 && third_q) begin
         m_q <= mul_l.p;
      end
   end

   // Region operands from the compensated value
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r1_q <= '0;
         r2_q <= '0;
      end else if (state_q == ST_DIV_WAIT && div_l.done) begin
         if (third_q) begin
            r1_q <= drift_compensated_value; // RULE10
            r2_q <= '0;
         end else begin
            r1_q <= (drift_compensated_value < brk_q) ?
               drift_compensated_value : brk_q; // RULE5
            r2_q <= (drift_compensated_value > brk_q) ?
               drift_compensated_value - brk_q : '0; // RULE6
         end
      end
   end

   // Output polynomial accumulation
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         g_q <= '0;
         sq_q <= '0;
         acc_q <= '0;
      end else if (state_q == ST_POLY) begin
         case (step_q)
            3'h0: g_q <= mul_l.p;
            3'h1: sq_q <= mul_l.p;
            3'h2: acc_q <= g_q + mul_l.p; // RULE8
            3'h3: begin
               if (!third_q) begin
                  g_q <= mul_l.p;
               end
            end
            3'h4: begin
               if (third_q) begin
                  acc_q <= acc_q + mul_l.p; // RULE10
               end else begin
                  sq_q <= mul_l.p;
               end
            end
            default: begin
               // Second region adds nothing when only one is calibrated
               if (!third_q && !single_q) begin
                  acc_q <= acc_q + g_q + mul_l.p; // RULE8 RULE9
               end
            end
         endcase
      end
   end

   // Registered results and completion pulse
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cap_q <= '0;
         temp_q <= '0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (state_q == ST_POLY && step_q == 3'h5) begin
            done_q <= 1'b1; // RULE18
         end
         if (state_q == ST_POLY && step_q == 3'h5 && (third_q || single_q)) begin
            cap_q <= cap_sat[OUT_W-1:0]; // RULE19
            temp_q <= temp_sat[COEF_W-1:0]; // RULE12
         end else if (state_q == ST_POLY && step_q == 3'h5) begin
            cap_q <= cap_two_sat[OUT_W-1:0]; // RULE19
            temp_q <= temp_sat[COEF_W-1:0];
         end
      end
   end
endmodule : sensor_correction_math
`default_nettype wire

// ---- sim/conv_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module conv_model
   import corr_pkg::*;
(
   // Clock
   input wire logic clk,
   // Sample pair toward the datapath
   output logic sample_valid,
   output raw_t raw_cap,
   output raw_t raw_temp
);
   initial begin
      sample_valid = 1'h0;
      raw_cap = 14'h0000;
      raw_temp = 14'h0000;
   end

   // Raw lines are not held after the pulse; inverting them exposes late sampling
   task automatic send(input raw_t c, input raw_t t, input int gap);
      for (int i = 0; i < gap; i++) begin
         @(posedge clk);
         #1;
      end
      sample_valid = 1'h1;
      raw_cap = c;
      raw_temp = t;
      @(posedge clk);
      #1;
      sample_valid = 1'h0;
      raw_cap = ~c;
      raw_temp = ~t;
   endtask : send
endmodule : conv_model
`default_nettype wire

// ---- sim/corr_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module corr_checker
   import corr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Watched ports
   input wire logic sample_valid,
   input wire logic busy,
   input wire logic result_done,
   input wire logic [OUT_W-1:0] cap_out,
   input wire logic [COEF_W-1:0] temp_out
);
   // Edges since the last accepted sample; 64 repetitions would be too many to unroll
   logic [6:0] age_q;
   logic [6:0] age_d;
   always_comb begin
      if (sample_valid && !busy) age_d = 7'h01;
      else if (age_q != 7'h00 && age_q < 7'h40) age_d = age_q + 7'h01;
      else age_d = 7'h00;
   end
   always_ff @(posedge clk) begin
      if (sys_rst) age_q <= 7'h00;
      else age_q <= age_d;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence accept_s;
      sample_valid && !busy;
   endsequence
   sequence run_s;
      busy ##63 (result_done && !busy);
   endsequence

   a_full_run: assert property (accept_s |=> run_s)
      else $error("result not 64 edges after accept");
   a_done_timing: assert property (result_done == (age_q == 7'h40))
      else $error("result_done at wrong cycle");
   a_busy_window: assert property (busy == (age_q != 7'h00 && age_q < 7'h40))
      else $error("busy outside run window");
   a_done_single: assert property (result_done |=> !result_done)
      else $error("result_done longer than one cycle");
   // Reset clears the results, so the edge right after it is not a hold cycle
   a_result_hold: assert property (!result_done && !$fell(sys_rst)
      |-> $stable(cap_out) && $stable(temp_out))
      else $error("results moved without result_done");
   a_reset_clean: assert property ($fell(sys_rst) |-> cap_out == '0 && temp_out == '0
      && !busy && !result_done)
      else $error("outputs not cleared by reset");
   a_idle_stays: assert property (!busy && !sample_valid |=> !busy)
      else $error("busy rose without a sample");
   a_done_ends_run: assert property (result_done |-> !busy && $past(busy))
      else $error("result_done not at end of run");
endmodule : corr_checker

bind sensor_correction_math corr_checker i_corr_checker (.clk(clk), .sys_rst(sys_rst),
   .sample_valid(sample_valid), .busy(busy), .result_done(result_done),
   .cap_out(cap_out), .temp_out(temp_out));
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench
   import corr_pkg::*;
;
   typedef struct packed {raw_t rc; raw_t rt; logic [1:0] res; logic third; logic single;} row_t;
   localparam int NROW = 6;
   localparam row_t ROWS [NROW] = '{
      '{14'h1000, 14'h2000, 2'h3, 1'h0, 1'h0},
      '{14'h3000, 14'h2000, 2'h3, 1'h0, 1'h0},
      '{14'h3000, 14'h2000, 2'h3, 1'h0, 1'h1},
      '{14'h3000, 14'h3FFF, 2'h2, 1'h0, 1'h0},
      '{14'h2800, 14'h1ABC, 2'h1, 1'h1, 1'h0},
      '{14'h0100, 14'h00FF, 2'h0, 1'h1, 1'h0}};
   logic clk, sys_rst, sample_valid, busy, result_done;
   raw_t raw_cap, raw_temp, tref, brk;
   logic [13:0] cap_out;
   logic [15:0] temp_out;
   coef_t off, od, odsq, sd, sdsq, g1, s1, g2, s2, tg, toff, tsq;
   row_t cur;
   int miscompares, total_checks, cyc;

   conv_model i_conv (.clk(clk), .sample_valid(sample_valid), .raw_cap(raw_cap),
      .raw_temp(raw_temp));
   sensor_correction_math i_sensor_correction_math (.clk(clk), .sys_rst(sys_rst),
      .sample_valid(sample_valid), .raw_cap(raw_cap), .raw_temp(raw_temp), .busy(busy),
      .temp_config({4'h8, cur.res, 10'h0A6}), .third_order(cur.third),
      .single_region(cur.single), .offset_coef(off), .offset_drift_coef(od),
      .offset_drift_square_coef(odsq), .slope_drift_coef(sd), .slope_drift_square_coef(sdsq),
      .temp_ref_raw(tref), .break_raw(brk), .region_one_gain(g1), .region_one_square_coef(s1),
      .region_two_gain(g2), .region_two_square_coef(s2), .temp_gain(tg), .temp_offset(toff),
      .temperature_square_coef(tsq), .cap_out(cap_out), .temp_out(temp_out),
      .result_done(result_done));

   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end

   task give_verdict;
      if (miscompares == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : give_verdict

   // Expected run length is under 1000 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         miscompares++;
         give_verdict();
      end
   end

   task chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic calc(input row_t r, output logic [13:0] ec, output logic [15:0] et);
      longint m, dt, ot, gt, c, a, b, g, sq, o;
      m = longint'(r.rt) % (longint'(1) << (8 + 2 * r.res));
      o = ((tsq * m * m) >>> 24) + ((tg * m) >>> 14) + toff;
      et = o < -32768 ? 16'h8000 : (o > 32767 ? 16'h7FFF : o[15:0]);
      dt = m - longint'(tref);
      ot = (dt * (od + ((dt * odsq) >>> 15))) >>> 15;
      gt = (dt * (sd + ((dt * sdsq) >>> 15))) >>> 15;
      c = (longint'(r.rc) - 8192 + off + ot) * 32768 / (32768 + gt) + 8192;
      a = (r.third || c < longint'(brk)) ? c : longint'(brk);
      b = c > longint'(brk) ? c - longint'(brk) : 0;
      g = (g1 * a) >>> 13;
      sq = (g * g) >>> 14;
      o = g + ((s1 * sq) >>> 15);
      if (r.third) o += (s2 * ((sq * g) >>> 14)) >>> 15;
      else if (!r.single) begin
         g = (g2 * b) >>> 13;
         o += g + ((s2 * ((g * g) >>> 14)) >>> 15);
      end
      ec = o < 0 ? 14'h0000 : (o > 16383 ? 14'h3FFF : o[13:0]);
   endtask : calc

   // A second sample sent mid-run must leave the first result untouched
   task automatic run_row(input row_t r, input int gap, input logic intrude);
      logic [13:0] ec;
      logic [15:0] et;
      int n;
      cur = r;
      calc(r, ec, et);
      i_conv.send(r.rc, r.rt, gap);
      if (intrude) i_conv.send(~r.rc, ~r.rt, 5);
      n = 0;
      while (result_done !== 1'h1 && n < 80) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(cap_out, ec);
      chk(temp_out, et);
      if (!intrude) chk(16'(n), 16'h003F);
   endtask : run_row

   initial begin
      logic seen;
      sys_rst = 1'h1;
      cur = ROWS[0];
      miscompares = 0;
      total_checks = 0;
      cyc = 0;
      {off, od, odsq, sd, sdsq} = {16'h0040, 16'h0200, 16'h0010, 16'h0100, 16'h0008};
      {g1, s1, g2, s2} = {16'h2000, 16'h0400, 16'h1800, 16'h0800};
      {tg, toff, tsq} = {16'h1000, 16'hF000, 16'h0100};
      tref = 14'h1000;
      brk = 14'h2000;
      repeat (10) @(posedge clk);
      #1;
      sys_rst = 1'h0;
      for (int i = 0; i < NROW; i++) run_row(ROWS[i], (i == 3) ? 3 : 0, 1'h0);
      run_row(ROWS[1], 0, 1'h1);
      g1 = 16'h7FFF;
      toff = 16'h7FFF;
      run_row(ROWS[1], 0, 1'h0);
      {g1, toff, tg} = {16'h8000, 16'h8000, 16'h8000};
      run_row(ROWS[1], 0, 1'h0);
      {g1, toff, tg} = {16'h2000, 16'hF000, 16'h1000};
      i_conv.send(ROWS[0].rc, ROWS[0].rt, 0);
      repeat (20) @(posedge clk);
      #1;
      sys_rst = 1'h1;
      @(posedge clk);
      #1;
      sys_rst = 1'h0;
      chk({14'h0000, busy, result_done}, 16'h0000);
      chk({2'h0, cap_out} | temp_out, 16'h0000);
      seen = 1'h0;
      repeat (70) begin
         @(posedge clk);
         #1;
         seen = seen | result_done;
      end
      chk({15'h0000, seen}, 16'h0000);
      run_row(ROWS[4], 0, 1'h0);
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
